// ### cbl_cfg_store.sv
// Purpose: nonvolatile image of the configuration bytes
// Assumes: flash-like program (bits only clear) and erase to all ones
// Notes: no reset on purpose, contents survive every reset
module cbl_cfg_store (
	input wire logic ref_clk,
	input wire logic wr_en,
	input wire logic erase_en,
	input wire logic erase_all,
	input wire logic [1:0] idx,
	input wire logic [7:0] wdata,
	output logic [cbl_pkg::CFG_NUM-1:0][7:0] bytes
);
	logic [7:0] mem [cbl_pkg::CFG_NUM];

	generate
		for (genvar i = 0; i < cbl_pkg::CFG_NUM; i++) begin : g_byte
			always_ff @(posedge ref_clk) begin
				if (erase_all || (erase_en && idx == 2'(i))) begin
					mem[i] <= cbl_pkg::ERASED;
				end else if (wr_en && idx == 2'(i)) begin
					mem[i] <= mem[i] & wdata;
				end
			end
			assign bytes[i] = mem[i];
		end
	endgenerate
endmodule : cbl_cfg_store

// ### cbl_loader.sv
// Purpose: configuration byte loader, option mirrors and programmer gate
// Assumes: flash macro read data valid in the cycle of flash_req_q
// Notes: por_flag and soft_flag held steady while rst_b is low
//
// What this block does
// - non-software reset boots application block when boot select is 1, else loader.
// - debug halt with float option 1 tri-states pwm pins; with 0 pwm continues.
// - the float option touches only channels whose pin select bit is 1.
// - debug port enable bit is active low.
// - debug mode with port enabled: hard fault sets flag, never resets.
// - reset pin disable 1 makes the pin a reset; 0 makes it input only.
// - locked chip returns all-ones to programmer flash reads.
// - locked chip ignores programmer flash program attempts.
// - config bytes always readable; locked blocks the programmer's single erase or program of them.
// - for the programmer only chip erase unlocks, and it erases flash and all config bits.
// - lock never restricts self programming by the core.
// - loader size field splits flash into loader and application blocks.
// - brown-out detect enable bit switches the detector.
// - brown-out level field picks 2.2, 2.7, 3.7 or 4.4 volts.
// - inhibit bit with detector on blocks self programming below threshold.
// - brown-out reset enable bit allows or suppresses brown-out reset.
// - watchdog field 1111 leaves a software general purpose timer.
// - watchdog field 0101 resets on time-out and stops in idle.
// - other watchdog values reset on time-out and keep counting in idle.
// - byte zero mirrors reload on every reset.
// - byte two mirrors reload on power-on reset only.
// - mirrors stay software writable between reloads.
module cbl_loader (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic por_flag,
	input wire logic soft_flag,
	output logic core_run_q,
	output logic boot_from_app_q,
	output logic [2:0] loader_kb_q,
	output logic [3:0] app_kb_q,
	input wire logic pgm_valid,
	input wire cbl_pkg::cbl_req_s pgm_cmd,
	output logic pgm_ack_q,
	output logic pgm_refused_q,
	output logic [7:0] pgm_rdata_q,
	input wire logic iap_valid,
	input wire cbl_pkg::cbl_req_s iap_cmd,
	output logic iap_ready,
	output logic iap_ack_q,
	output logic iap_refused_q,
	output logic [7:0] iap_rdata_q,
	output logic flash_req_q,
	output cbl_pkg::cbl_req_s flash_cmd_q,
	input wire logic [7:0] flash_rdata,
	input wire logic sfr_wr,
	input wire logic sfr_sel,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_byte0_q,
	output logic [7:0] sfr_byte2_q,
	output logic debug_port_en,
	input wire logic debug_mode,
	input wire logic debug_halt,
	input wire logic [cbl_pkg::PWM_CH-1:0] pwm_pin_select,
	input wire logic [cbl_pkg::PWM_CH-1:0] pwm_out,
	output logic [cbl_pkg::PWM_CH-1:0] pwm_pin_o,
	output logic [cbl_pkg::PWM_CH-1:0] pwm_pin_oe,
	input wire logic hard_fault,
	input wire logic hf_clr,
	output logic hf_flag_q,
	output logic hf_reset_req_q,
	input wire logic reset_pin_n,
	output logic ext_reset_req_q,
	output logic port_bit_q,
	input wire logic vdd_below_bod,
	output logic bod_enable_q,
	output logic [12:0] bod_mv_q,
	output logic bod_reset_req_q,
	output logic wdt_reset_en_q,
	output logic wdt_run_in_idle_q
);
	cbl_pkg::cbl_state_e state_q;
	logic por_seen_q;
	logic soft_seen_q;
	logic [cbl_pkg::CFG_NUM-1:0][7:0] nv_bytes;
	logic [2:0] dec_loader_kb;
	logic [3:0] dec_app_kb;
	cbl_pkg::cbl_wdt_s dec_wdt;
	logic [12:0] dec_bod_mv;
	logic [2:0] lds_q;
	logic [3:0] wdt_q;
	logic locked;
	logic sel_pgm;
	logic sel_iap;
	cbl_pkg::cbl_req_s req;
	logic is_write;
	logic bo_block;
	logic refuse;
	logic s1_valid_q;
	logic s1_pgm_q;
	logic s1_cfg_q;
	logic s1_mask_q;
	logic s1_refuse_q;
	logic [1:0] s1_idx_q;
	logic [7:0] rdata;
	logic st_wr;
	logic st_erase;
	logic st_all;

	// reset kind is caught while reset is held, for use at the load
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			por_seen_q <= por_flag;
			soft_seen_q <= soft_flag;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			state_q <= cbl_pkg::ST_LOAD;
			core_run_q <= 1'b0;
		end else begin
			case (state_q)
				cbl_pkg::ST_LOAD: begin
					// held one more edge: the decoded split registers a cycle after the copy
					state_q <= cbl_pkg::ST_RUN;
					core_run_q <= 1'b0;
				end
				cbl_pkg::ST_RUN: core_run_q <= 1'b1;
				default: begin
					state_q <= cbl_pkg::ST_LOAD;
					core_run_q <= 1'b0;
				end
			endcase
		end
	end

	// fields copied in the load cycle, core held until then
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			lds_q <= cbl_pkg::LDS_NONE;
			wdt_q <= cbl_pkg::WDT_OFF;
		end else if (state_q == cbl_pkg::ST_LOAD) begin
			lds_q <= nv_bytes[cbl_pkg::IDX_LOADER][cbl_pkg::LDS_LSB +: 3];
			wdt_q <= nv_bytes[cbl_pkg::IDX_WDT][cbl_pkg::WDT_LSB +: 4];
		end
	end

	// boot select: a software reset keeps whatever software left in the mirror
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			boot_from_app_q <= 1'b1;
		end else if (state_q == cbl_pkg::ST_LOAD && !soft_seen_q) begin
			boot_from_app_q <= nv_bytes[cbl_pkg::IDX_BYTE0][cbl_pkg::B0_BOOT];
		end else if (state_q == cbl_pkg::ST_LOAD) begin
			boot_from_app_q <= sfr_byte0_q[cbl_pkg::B0_BOOT];
		end
	end

	// mirrors are not cleared by reset; the load cycle is their only reload
	always_ff @(posedge ref_clk) begin
		if (state_q == cbl_pkg::ST_LOAD && rst_b) begin
			sfr_byte0_q <= nv_bytes[cbl_pkg::IDX_BYTE0];
		end else if (sfr_wr && !sfr_sel && core_run_q) begin
			sfr_byte0_q <= sfr_wdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (state_q == cbl_pkg::ST_LOAD && rst_b && por_seen_q) begin
			sfr_byte2_q <= nv_bytes[cbl_pkg::IDX_BYTE2];
		end else if (sfr_wr && sfr_sel && core_run_q) begin
			sfr_byte2_q <= sfr_wdata;
		end
	end

	cbl_option_decode u_decode (
		.lds(lds_q),
		.wdt(wdt_q),
		.lvl(sfr_byte2_q[cbl_pkg::B2_LVL_LSB +: 2]),
		.loader_kb(dec_loader_kb),
		.app_kb(dec_app_kb),
		.wdt_mode(dec_wdt),
		.bod_mv(dec_bod_mv)
	);

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			loader_kb_q <= 3'h0;
			app_kb_q <= cbl_pkg::FLASH_KB;
			wdt_reset_en_q <= 1'b0;
			wdt_run_in_idle_q <= 1'b0;
			bod_mv_q <= cbl_pkg::MV_2V2;
		end else begin
			loader_kb_q <= dec_loader_kb;
			app_kb_q <= dec_app_kb;
			wdt_reset_en_q <= dec_wdt.reset_en;
			wdt_run_in_idle_q <= dec_wdt.run_in_idle;
			bod_mv_q <= dec_bod_mv;
		end
	end

	// brown-out: detector, reset request, level from the software mirror
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			bod_enable_q <= 1'b0;
			bod_reset_req_q <= 1'b0;
		end else begin
			bod_enable_q <= sfr_byte2_q[cbl_pkg::B2_BODEN];
			bod_reset_req_q <= sfr_byte2_q[cbl_pkg::B2_BODEN] && vdd_below_bod &&
				sfr_byte2_q[cbl_pkg::B2_BRST];
		end
	end

	assign debug_port_en = core_run_q && !sfr_byte0_q[cbl_pkg::B0_DBGN];

	generate
		for (genvar c = 0; c < cbl_pkg::PWM_CH; c++) begin : g_pwm
			assign pwm_pin_o[c] = pwm_out[c];
			assign pwm_pin_oe[c] = pwm_pin_select[c] &&
				!(debug_halt && sfr_byte0_q[cbl_pkg::B0_PWMF]);
		end
	endgenerate

	// hard fault in an active debug session only flags; set wins over clear
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			hf_flag_q <= 1'b0;
			hf_reset_req_q <= 1'b0;
		end else begin
			hf_reset_req_q <= hard_fault && !(debug_mode && debug_port_en);
			if (hard_fault && debug_mode && debug_port_en) begin
				hf_flag_q <= 1'b1;
			end else if (hf_clr) begin
				hf_flag_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			ext_reset_req_q <= 1'b0;
			port_bit_q <= 1'b0;
		end else begin
			ext_reset_req_q <= sfr_byte0_q[cbl_pkg::B0_RPD] && !reset_pin_n;
			port_bit_q <= sfr_byte0_q[cbl_pkg::B0_RPD] ? 1'b0 : reset_pin_n;
		end
	end

	// access gate: programmer always wins the cycle over self programming
	assign locked = !nv_bytes[cbl_pkg::IDX_BYTE0][cbl_pkg::B0_LOCK];
	assign sel_pgm = pgm_valid;
	assign iap_ready = !pgm_valid;
	assign sel_iap = iap_valid && !pgm_valid;
	assign req = sel_pgm ? pgm_cmd : iap_cmd;
	assign is_write = (req.cmd == cbl_pkg::CMD_PROG) || (req.cmd == cbl_pkg::CMD_ERASE);
	assign bo_block = sfr_byte2_q[cbl_pkg::B2_BODEN] && sfr_byte2_q[cbl_pkg::B2_INH] &&
		vdd_below_bod;

	always_comb begin
		if (sel_pgm) begin
			refuse = locked && is_write;
		end else begin
			// lock is not consulted here; the core may not wipe the chip
			refuse = (is_write && bo_block) || (req.cmd == cbl_pkg::CMD_CHIP_ERASE);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			s1_valid_q <= 1'b0;
			s1_pgm_q <= 1'b0;
			s1_cfg_q <= 1'b0;
			s1_mask_q <= 1'b0;
			s1_refuse_q <= 1'b0;
			s1_idx_q <= 2'h0;
			flash_req_q <= 1'b0;
			flash_cmd_q <= '0;
		end else begin
			s1_valid_q <= sel_pgm || sel_iap;
			s1_pgm_q <= sel_pgm;
			s1_cfg_q <= req.cfg_space;
			s1_mask_q <= sel_pgm && locked && !req.cfg_space;
			s1_refuse_q <= refuse;
			s1_idx_q <= req.addr[1:0];
			flash_req_q <= (sel_pgm || sel_iap) && !refuse &&
				(!req.cfg_space || req.cmd == cbl_pkg::CMD_CHIP_ERASE);
			flash_cmd_q <= req;
		end
	end

	// config writes land one cycle after acceptance, in the cycle of flash_req_q, which only chip erase raises for them
	assign st_wr = s1_valid_q && s1_cfg_q && !s1_refuse_q && flash_cmd_q.cmd == cbl_pkg::CMD_PROG;
	assign st_erase = s1_valid_q && s1_cfg_q && !s1_refuse_q &&
		flash_cmd_q.cmd == cbl_pkg::CMD_ERASE;
	assign st_all = s1_valid_q && !s1_refuse_q &&
		flash_cmd_q.cmd == cbl_pkg::CMD_CHIP_ERASE;

	cbl_cfg_store u_store (
		.ref_clk(ref_clk),
		.wr_en(st_wr),
		.erase_en(st_erase),
		.erase_all(st_all),
		.idx(s1_idx_q),
		.wdata(flash_cmd_q.wdata),
		.bytes(nv_bytes)
	);

	// config bytes never masked, flash masked to erased for a locked programmer
	assign rdata = s1_cfg_q ? nv_bytes[s1_idx_q] :
		(s1_mask_q ? cbl_pkg::ERASED : flash_rdata);

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			pgm_ack_q <= 1'b0;
			pgm_refused_q <= 1'b0;
			pgm_rdata_q <= 8'h00;
			iap_ack_q <= 1'b0;
			iap_refused_q <= 1'b0;
			iap_rdata_q <= 8'h00;
		end else begin
			pgm_ack_q <= s1_valid_q && s1_pgm_q;
			pgm_refused_q <= s1_valid_q && s1_pgm_q && s1_refuse_q;
			iap_ack_q <= s1_valid_q && !s1_pgm_q;
			iap_refused_q <= s1_valid_q && !s1_pgm_q && s1_refuse_q;
			if (s1_valid_q && s1_pgm_q) begin
				pgm_rdata_q <= rdata;
			end
			if (s1_valid_q && !s1_pgm_q) begin
				iap_rdata_q <= rdata;
			end
		end
	end

	property p_boot;
		@(posedge ref_clk) disable iff (!rst_b)
		$rose(core_run_q) && !soft_seen_q |->
			boot_from_app_q == $past(nv_bytes[cbl_pkg::IDX_BYTE0][cbl_pkg::B0_BOOT]);
	endproperty
	a_boot: assert property (p_boot) else $error("boot select not loaded");

	property p_pwm_float;
		@(posedge ref_clk) disable iff (!rst_b)
		debug_halt && sfr_byte0_q[cbl_pkg::B0_PWMF] |-> pwm_pin_oe == '0;
	endproperty
	a_pwm_float: assert property (p_pwm_float) else $error("pwm pin driven in halt");

	property p_hard_fault;
		@(posedge ref_clk) disable iff (!rst_b)
		hard_fault && debug_mode && debug_port_en |=> hf_flag_q && !hf_reset_req_q;
	endproperty
	a_hard_fault: assert property (p_hard_fault) else $error("hard fault reset in debug");

	property p_reset_pin;
		@(posedge ref_clk) disable iff (!rst_b)
		!sfr_byte0_q[cbl_pkg::B0_RPD] && core_run_q |=> !ext_reset_req_q;
	endproperty
	a_reset_pin: assert property (p_reset_pin) else $error("pin reset while disabled");

	property p_lock_read;
		@(posedge ref_clk) disable iff (!rst_b)
		sel_pgm && locked && !req.cfg_space && req.cmd == cbl_pkg::CMD_READ |->
			##2 pgm_ack_q && pgm_rdata_q == cbl_pkg::ERASED;
	endproperty
	a_lock_read: assert property (p_lock_read) else $error("locked read not masked");

	property p_lock_prog;
		@(posedge ref_clk) disable iff (!rst_b)
		sel_pgm && locked && req.cmd == cbl_pkg::CMD_PROG |=> !flash_req_q ##1 pgm_refused_q;
	endproperty
	a_lock_prog: assert property (p_lock_prog) else $error("locked program took effect");

	property p_cfg_read;
		@(posedge ref_clk) disable iff (!rst_b)
		sel_pgm && req.cfg_space && req.cmd == cbl_pkg::CMD_READ |->
			##2 pgm_ack_q && !pgm_refused_q;
	endproperty
	a_cfg_read: assert property (p_cfg_read) else $error("config read refused");

	property p_iap_lock;
		@(posedge ref_clk) disable iff (!rst_b)
		sel_iap && locked && !bo_block && req.cmd == cbl_pkg::CMD_PROG && !req.cfg_space
			|=> flash_req_q;
	endproperty
	a_iap_lock: assert property (p_iap_lock) else $error("lock blocked self program");

	property p_bo_inhibit;
		@(posedge ref_clk) disable iff (!rst_b)
		sel_iap && bo_block && is_write |-> ##1 !flash_req_q ##1 iap_refused_q;
	endproperty
	a_bo_inhibit: assert property (p_bo_inhibit) else $error("program below threshold");

	property p_byte2_hold;
		@(posedge ref_clk) disable iff (!rst_b)
		$rose(core_run_q) && !por_seen_q |-> $stable(sfr_byte2_q);
	endproperty
	a_byte2_hold: assert property (p_byte2_hold) else $error("byte two reloaded");
endmodule : cbl_loader

// ### cbl_option_decode.sv
// Purpose: decode option fields into sizes, modes and thresholds
// Assumes: fields already aligned to bit zero
// Notes: purely combinational
module cbl_option_decode (
	input wire logic [2:0] lds,
	input wire logic [3:0] wdt,
	input wire logic [1:0] lvl,
	output logic [2:0] loader_kb,
	output logic [3:0] app_kb,
	output cbl_pkg::cbl_wdt_s wdt_mode,
	output logic [12:0] bod_mv
);
	always_comb begin
		case (lds)
			cbl_pkg::LDS_NONE: loader_kb = 3'h0;
			cbl_pkg::LDS_1K: loader_kb = 3'h1;
			cbl_pkg::LDS_2K: loader_kb = 3'h2;
			cbl_pkg::LDS_3K: loader_kb = 3'h3;
			default: loader_kb = 3'h4;
		endcase
		app_kb = cbl_pkg::FLASH_KB - {1'b0, loader_kb};
		wdt_mode.reset_en = (wdt != cbl_pkg::WDT_OFF);
		wdt_mode.run_in_idle = wdt_mode.reset_en && (wdt != cbl_pkg::WDT_STOP_IDLE);
		case (lvl)
			cbl_pkg::LVL_2V2: bod_mv = cbl_pkg::MV_2V2;
			cbl_pkg::LVL_2V7: bod_mv = cbl_pkg::MV_2V7;
			cbl_pkg::LVL_3V7: bod_mv = cbl_pkg::MV_3V7;
			default: bod_mv = cbl_pkg::MV_4V4;
		endcase
	end
endmodule : cbl_option_decode

// ### cbl_pkg.sv
// Purpose: shared constants and types for the configuration byte loader
// Assumes: 8 KB flash, four configuration bytes, 8-bit core
// Notes: bit positions are within each configuration byte
package cbl_pkg;
	localparam int CFG_NUM = 4;
	localparam logic [1:0] IDX_BYTE0 = 2'h0;
	localparam logic [1:0] IDX_LOADER = 2'h1;
	localparam logic [1:0] IDX_BYTE2 = 2'h2;
	localparam logic [1:0] IDX_WDT = 2'h3;
	localparam logic [7:0] ERASED = 8'hff;
	// config byte zero
	localparam int B0_BOOT = 7;
	localparam int B0_PWMF = 5;
	localparam int B0_DBGN = 4;
	localparam int B0_RPD = 2;
	localparam int B0_LOCK = 1;
	// loader size byte and watchdog byte
	localparam int LDS_LSB = 0;
	localparam int WDT_LSB = 4;
	localparam logic [2:0] LDS_NONE = 3'h7;
	localparam logic [2:0] LDS_1K = 3'h6;
	localparam logic [2:0] LDS_2K = 3'h5;
	localparam logic [2:0] LDS_3K = 3'h4;
	localparam logic [3:0] FLASH_KB = 4'h8;
	localparam logic [3:0] WDT_OFF = 4'hf;
	localparam logic [3:0] WDT_STOP_IDLE = 4'h5;
	// config byte two
	localparam int B2_BODEN = 7;
	localparam int B2_LVL_LSB = 4;
	localparam int B2_INH = 3;
	localparam int B2_BRST = 2;
	localparam logic [1:0] LVL_2V2 = 2'h3;
	localparam logic [1:0] LVL_2V7 = 2'h2;
	localparam logic [1:0] LVL_3V7 = 2'h1;
	localparam logic [12:0] MV_2V2 = 13'h0898;
	localparam logic [12:0] MV_2V7 = 13'h0a8c;
	localparam logic [12:0] MV_3V7 = 13'h0e74;
	localparam logic [12:0] MV_4V4 = 13'h1130;
	localparam int PWM_CH = 6;

	typedef enum logic [1:0] {
		CMD_READ = 2'b00,
		CMD_PROG = 2'b01,
		CMD_ERASE = 2'b10,
		CMD_CHIP_ERASE = 2'b11
	} cbl_cmd_e;

	typedef enum logic [1:0] {
		ST_LOAD = 2'b00,
		ST_RUN = 2'b01
	} cbl_state_e;

	typedef struct packed {
		cbl_cmd_e cmd;
		logic cfg_space;
		logic [13:0] addr;
		logic [7:0] wdata;
	} cbl_req_s;

	typedef struct packed {
		logic reset_en;
		logic run_in_idle;
	} cbl_wdt_s;
endpackage : cbl_pkg

// ### cbl_prog_model.sv
// Purpose: external programmer plus flash array seen by the loader
// Assumes: one request per call, entered at a falling edge
// Notes: flash data floats (inverted) outside a request
module cbl_prog_model (
	input wire logic ref_clk,
	output logic pgm_valid,
	output cbl_pkg::cbl_req_s pgm_cmd,
	input wire logic flash_req_q,
	input wire cbl_pkg::cbl_req_s flash_cmd_q,
	output logic [7:0] flash_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [64];
	initial begin
		pgm_valid = 1'b0;
		pgm_cmd = '0;
		foreach (mem[i]) mem[i] = 8'h5a;
	end
	// a stale bus value would hide a missed request, so show its inverse
	assign flash_rdata = flash_req_q ? mem[flash_cmd_q.addr[5:0]] : ~mem[flash_cmd_q.addr[5:0]];
	always @(posedge ref_clk) begin
		if (flash_req_q) begin
			if (flash_cmd_q.cmd == cbl_pkg::CMD_CHIP_ERASE) begin
				foreach (mem[i]) mem[i] = 8'hff;
			end else if (!flash_cmd_q.cfg_space && flash_cmd_q.cmd == cbl_pkg::CMD_PROG) begin
				mem[flash_cmd_q.addr[5:0]] &= flash_cmd_q.wdata;
			end else if (!flash_cmd_q.cfg_space && flash_cmd_q.cmd == cbl_pkg::CMD_ERASE) begin
				mem[flash_cmd_q.addr[5:0]] = 8'hff;
			end
		end
	end
	task send(input cbl_pkg::cbl_cmd_e c, input logic cs, input logic [13:0] a,
		input logic [7:0] d);
		pgm_cmd = '{c, cs, a, d};
		pgm_valid = 1'b1;
		@(negedge ref_clk);
		pgm_valid = 1'b0;
		pgm_cmd = cbl_pkg::cbl_req_s'(~pgm_cmd);
	endtask : send
endmodule : cbl_prog_model

// ### tb_top.sv
// Purpose: self-checking bench for the configuration byte loader
// Assumes: inputs change on falling edges, outputs sampled there
// Notes: reserved config bits are written as ones to the store; the mirror writes in t_mirror clear some
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam cbl_pkg::cbl_cmd_e RD = cbl_pkg::CMD_READ;
	localparam cbl_pkg::cbl_cmd_e PR = cbl_pkg::CMD_PROG;
	localparam cbl_pkg::cbl_cmd_e ER = cbl_pkg::CMD_ERASE;
	localparam cbl_pkg::cbl_cmd_e CE = cbl_pkg::CMD_CHIP_ERASE;
	logic ref_clk = 0, rst_b = 0, por_flag = 1, soft_flag = 0;
	logic iap_valid = 0, sfr_wr = 0, sfr_sel = 0, debug_mode = 0, debug_halt = 0;
	logic hard_fault = 0, hf_clr = 0, reset_pin_n = 1, vdd_below_bod = 0;
	logic [7:0] sfr_wdata = 0;
	logic [5:0] pwm_pin_select = 0, pwm_out = 0, pwm_pin_o, pwm_pin_oe;
	logic core_run_q, boot_from_app_q, pgm_valid, pgm_ack_q, pgm_refused_q, iap_ready;
	logic iap_ack_q, iap_refused_q, flash_req_q, debug_port_en, hf_flag_q, hf_reset_req_q;
	logic ext_reset_req_q, port_bit_q, bod_enable_q, bod_reset_req_q;
	logic wdt_reset_en_q, wdt_run_in_idle_q;
	logic [2:0] loader_kb_q;
	logic [3:0] app_kb_q;
	logic [7:0] pgm_rdata_q, iap_rdata_q, flash_rdata, sfr_byte0_q, sfr_byte2_q;
	logic [12:0] bod_mv_q;
	cbl_pkg::cbl_req_s pgm_cmd, iap_cmd = '0, flash_cmd_q;
	int fail_count = 0, n_tests = 0;
	logic [2:0] lds_t [5] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h0};
	logic [1:0] lvl_t [5] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h3};
	logic [3:0] wdt_t [5] = '{4'hf, 4'h5, 4'h0, 4'ha, 4'h5};
	logic [12:0] mv_t [5] = '{cbl_pkg::MV_2V2, cbl_pkg::MV_2V7, cbl_pkg::MV_3V7,
		cbl_pkg::MV_4V4, cbl_pkg::MV_2V2};

	cbl_loader uut (.*);
	cbl_prog_model pm (.*);

	initial forever #5 ref_clk = ~ref_clk;

	task final_report();
		if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : final_report
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task wait_ack(input logic self_programming);
		int k;
		for (k = 0; k < 8 && (self_programming ? iap_ack_q : pgm_ack_q) !== 1'b1; k++) @(negedge ref_clk);
		if (k == 8) begin
			fail_count++;
			final_report();
		end
	endtask : wait_ack
	task pg(input cbl_pkg::cbl_cmd_e c, input logic cs, input logic [13:0] a,
		input logic [7:0] d, input logic er);
		pm.send(c, cs, a, d);
		wait_ack(1'b0);
		chk(pgm_refused_q, er);
	endtask : pg
	task ip(input cbl_pkg::cbl_cmd_e c, input logic [13:0] a, input logic [7:0] d,
		input logic er);
		chk(iap_ready, 1);
		iap_cmd = '{c, 1'b0, a, d};
		iap_valid = 1;
		@(negedge ref_clk);
		iap_valid = 0;
		iap_cmd = cbl_pkg::cbl_req_s'(~iap_cmd);
		wait_ack(1'b1);
		chk(iap_refused_q, er);
	endtask : ip
	task sw(input logic s, input logic [7:0] d);
		sfr_sel = s;
		sfr_wdata = d;
		sfr_wr = 1;
		@(negedge ref_clk);
		sfr_wr = 0;
		@(negedge ref_clk);
	endtask : sw
	task rs(input logic p, input logic s);
		rst_b = 0;
		por_flag = p;
		soft_flag = s;
		repeat (5) @(negedge ref_clk);
		rst_b = 1;
		@(negedge ref_clk);
		chk(core_run_q, 0);
		@(negedge ref_clk);
		chk(core_run_q, 1);
		@(negedge ref_clk);
	endtask : rs
	// byte zero goes last: clearing its lock bit freezes the others at once
	task cfg(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
		input logic [7:0] b3);
		pg(CE, 1, 0, 0, 0);
		pg(PR, 1, 3, b3, 0);
		pg(PR, 1, 2, b2, 0);
		pg(PR, 1, 1, b1, 0);
		pg(PR, 1, 0, b0, 0);
		rs(1, 0);
	endtask : cfg
	task look(input int sel, input logic exp);
		logic s;
		s = 0;
		// the request stands one cycle, so the current cycle is looked at first
		repeat (3) begin
			case (sel)
				0: s = s | hf_reset_req_q;
				1: s = s | ext_reset_req_q;
				default: s = s | bod_reset_req_q;
			endcase
			@(negedge ref_clk);
		end
		chk(s, exp);
	endtask : look
	task t_decode();
		logic [7:0] b0, b2;
		for (int i = 0; i < 5; i++) begin
			b0 = {i != 1, 7'h6f};
			b2 = {i != 2, 1'b1, lvl_t[i], 4'hf};
			cfg(b0, {5'h1f, lds_t[i]}, b2, {wdt_t[i], 4'hf});
			chk(boot_from_app_q, i != 1);
			chk(loader_kb_q, i);
			chk(app_kb_q, 8 - i);
			chk(bod_enable_q, i != 2);
			chk(bod_mv_q, mv_t[i]);
			chk(wdt_reset_en_q, i != 0);
			if (i != 0) chk(wdt_run_in_idle_q, wdt_t[i] != 4'h5);
			chk(sfr_byte0_q, b0);
			chk(sfr_byte2_q, b2);
			chk(debug_port_en, 1);
		end
	endtask : t_decode
	task t_mirror();
		cfg(8'hef, 8'hfe, 8'hef, 8'h5f);
		sw(0, 8'hab);
		chk(sfr_byte0_q, 8'hab);
		sw(1, 8'h12);
		chk(sfr_byte2_q, 8'h12);
		rs(0, 0);
		chk(sfr_byte0_q, 8'hef);
		chk(sfr_byte2_q, 8'h12);
		sw(0, 8'h00);
		rs(0, 1);
		chk(sfr_byte0_q, 8'hef);
		chk(boot_from_app_q, 0);
		rs(1, 0);
		chk(sfr_byte2_q, 8'hef);
	endtask : t_mirror
	task t_pwm();
		sw(0, 8'hef);
		pwm_pin_select = 6'h2b;
		pwm_out = 6'h15;
		@(negedge ref_clk);
		chk(pwm_pin_o, 6'h15);
		chk(pwm_pin_oe & 6'h2b, 6'h2b);
		debug_halt = 1;
		@(negedge ref_clk);
		chk(pwm_pin_oe & 6'h2b, 6'h00);
		chk(pwm_pin_oe & ~6'h2b, 6'h00);
		sw(0, 8'hcf);
		chk(pwm_pin_oe & 6'h2b, 6'h2b);
		debug_halt = 0;
	endtask : t_pwm
	task t_hf();
		sw(0, 8'hef);
		debug_mode = 1;
		hard_fault = 1;
		@(negedge ref_clk);
		hard_fault = 0;
		look(0, 0);
		chk(hf_flag_q, 1);
		hf_clr = 1;
		@(negedge ref_clk);
		hf_clr = 0;
		@(negedge ref_clk);
		chk(hf_flag_q, 0);
		sw(0, 8'hff);
		chk(debug_port_en, 0);
		hard_fault = 1;
		@(negedge ref_clk);
		hard_fault = 0;
		look(0, 1);
		debug_mode = 0;
	endtask : t_hf
	task t_pin();
		sw(0, 8'hef);
		reset_pin_n = 0;
		look(1, 1);
		chk(port_bit_q, 0);
		reset_pin_n = 1;
		sw(0, 8'heb);
		reset_pin_n = 0;
		look(1, 0);
		chk(port_bit_q, 0);
		reset_pin_n = 1;
		repeat (2) @(negedge ref_clk);
		chk(port_bit_q, 1);
	endtask : t_pin
	task t_bod();
		vdd_below_bod = 1;
		look(2, 1);
		ip(PR, 7, 8'h00, 1);
		sw(1, 8'he3);
		look(2, 0);
		ip(PR, 7, 8'h00, 0);
		sw(1, 8'h6f);
		chk(bod_enable_q, 0);
		ip(PR, 7, 8'hf0, 0);
		vdd_below_bod = 0;
	endtask : t_bod
	task t_lock();
		cfg(8'hef, 8'hfe, 8'hef, 8'h5f);
		pg(PR, 0, 5, 8'h3c, 0);
		pg(ER, 1, 3, 0, 0);
		pg(RD, 1, 3, 0, 0);
		chk(pgm_rdata_q, 8'hff);
		pg(PR, 1, 0, 8'hed, 0);
		pg(RD, 0, 5, 0, 0);
		chk(pgm_rdata_q, 8'hff);
		pg(PR, 0, 5, 8'h00, 1);
		chk(pm.mem[5], 8'h3c);
		pg(RD, 1, 0, 0, 0);
		chk(pgm_rdata_q, 8'hed);
		pg(PR, 1, 1, 8'h00, 1);
		pg(ER, 1, 1, 0, 1);
		ip(PR, 5, 8'h0c, 0);
		chk(pm.mem[5], 8'h0c);
		ip(RD, 5, 8'h00, 0);
		chk(iap_rdata_q, 8'h0c);
		ip(CE, 0, 0, 1);
		pg(CE, 1, 0, 0, 0);
		pg(RD, 0, 5, 0, 0);
		chk(pgm_rdata_q, 8'hff);
		pg(RD, 1, 0, 0, 0);
		chk(pgm_rdata_q, 8'hff);
	endtask : t_lock

	initial begin
		// store still unwritten here: marked soft so the boot check skips it, power-on so the hold check skips it
		rs(1, 1);
		t_decode();
		t_mirror();
		t_pwm();
		t_hf();
		t_pin();
		t_bod();
		t_lock();
		final_report();
	end
endmodule : tb_top
